// [hw/fss_defs.svh]
// Purpose : Register map, field positions and reset values of the frame statistics sequencer
// Assumes : Byte offsets on a 32-bit register port
// Notes   : Definitions only
`ifndef FSS_DEFS_SVH
`define FSS_DEFS_SVH

// ==========================================================
// Register offsets
`define FSS_ADDR_W          12
`define FSS_OFS_CONTROL     12'h000
`define FSS_OFS_STATUS      12'h004
`define FSS_OFS_IRQ_EN      12'h008
`define FSS_OFS_FRAME_CNT   12'h014
`define FSS_OFS_LINE_CNT    12'h018
`define FSS_OFS_PIXEL_CNT   12'h01C
`define FSS_OFS_COL_LIMIT   12'h020
`define FSS_OFS_ROW_LIMIT   12'h024
`define FSS_OFS_COLOR_SEL   12'h028
`define FSS_OFS_LUMA_SEL    12'h02C
`define FSS_OFS_SCALE       12'h030
`define FSS_OFS_RESULT_VLD  12'h190

// ==========================================================
// Field positions and reset values
`define FSS_CTRL_COMMIT_BIT 1
`define FSS_CTRL_HOLD_BIT   6
`define FSS_STAT_DONE_BIT   4
`define FSS_IRQ_DONE_BIT    0
`define FSS_RST_CONTROL     32'h0000_0000
`define FSS_RST_LIMIT       16'hFFFF
`define FSS_RST_SEL         16'h0001
`define FSS_RST_SCALE       4'h0
`define FSS_MAX_DATA_W      12
`define FSS_BUF_DEPTH       2

`endif

// [hw/fss_pkg.sv]
// Purpose : Types shared by the frame statistics sequencer files
// Assumes : fss_defs.svh gives the widths
// Notes   : States are one-hot
`include "fss_defs.svh"
package fss_pkg;

  // ==========================================================
  // Sequencer states
  typedef enum logic [3:0] {
    ST_INIT = 4'b0001,
    ST_WAIT = 4'b0010,
    ST_ACQ  = 4'b0100,
    ST_READ = 4'b1000
  } seq_state_t;

  // ==========================================================
  // Pixel word: sample, end of line, end of active frame
  typedef struct packed {
    logic                          eaf;
    logic                          eol;
    logic [`FSS_MAX_DATA_W-1:0]    data;
  } pix_t;

  // Zone and histogram settings, shadow and active copies
  typedef struct packed {
    logic [15:0] col_limit;
    logic [15:0] row_limit;
    logic [15:0] color_sel;
    logic [15:0] luma_sel;
    logic [3:0]  scale;
  } cfg_t;

endpackage

// [hw/fss_pix_buffer.sv]
// Purpose : Small FIFO between the pixel source and the sequencer
// Assumes : Single clock, synchronous active-high reset
// Notes   : Ready toward the source drops when full, so a stall loses nothing
`timescale 1ns/1ns
module fss_pix_buffer #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 2
) (
  input  wire logic             i_clk,
  input  wire logic             i_srst,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
      $error("fss_pix_buffer: DEPTH must be a power of two >= 2");
    end
  end

  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW:0]      wr_ptr_ff, rd_ptr_ff, nxt_wr_ptr, nxt_rd_ptr;
  logic             push, pop, full, empty;

  // ==========================================================
  // Pointer control
  always_comb begin
    full        = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) && (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
    empty       = (wr_ptr_ff == rd_ptr_ff);
    o_in_ready  = !full;
    o_out_valid = !empty;
    o_out_data  = mem[rd_ptr_ff[AW-1:0]];
    push        = i_in_valid && !full;
    pop         = i_out_ready && !empty;
    nxt_wr_ptr  = push ? wr_ptr_ff + 1'b1 : wr_ptr_ff;
    nxt_rd_ptr  = pop ? rd_ptr_ff + 1'b1 : rd_ptr_ff;
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
    end
  end

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr_ff[AW-1:0]] <= i_in_data;
    end
  end
endmodule

// [hw/fss_event_counter.sv]
// Purpose : Free-running event counter read back by software
// Assumes : Single clock, synchronous active-high reset
// Notes   : Wraps at full scale
`timescale 1ns/1ns
module fss_event_counter #(
  parameter int WIDTH = 32
) (
  input  wire logic             i_clk,
  input  wire logic             i_srst,
  input  wire logic             i_inc,
  output logic      [WIDTH-1:0] o_count
);
  initial begin
    if (WIDTH < 1) begin
      $error("fss_event_counter: WIDTH must be positive");
    end
  end

  logic [WIDTH-1:0] count_ff, nxt_count;

  always_comb begin
    nxt_count = i_inc ? count_ff + 1'b1 : count_ff;
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      count_ff <= '0;
    end else begin
      count_ff <= nxt_count;
    end
  end

  assign o_count = count_ff;
endmodule

// [hw/frame_stats_sequencer.sv]
// Purpose : Frame sequencing, readout handshake, shadow commit and throughput counters
// Assumes : Pixels, markers and register port all synchronous to I_CLK
// Notes   : The histogram here is a plain per-value count that stands in for the statistics
`timescale 1ns/1ns
`include "fss_defs.svh"

// Functional notes
// - Frame counter readable, counts frames since power-up or reset.
// - Line counter readable, counts scan-lines since power-up or reset.
// - Pixel counter readable, counts pixels since power-up or reset.
// - After reset: initialize, then wait for frame start, then acquire.
// - Initialization clears histogram memory in 256, 1024 or 4096 cycles by precision.
// - After clearing, wait for frame begin rising edge, then acquire.
// - Measurements update only from pixels with the qualifier high.
// - Hold flag clear at end of acquisition: back to initialization after last line.
// - Hold flag (control bit 6) set: enter readout at end of active frame.
// - In readout, stop collecting and enable the result fetch path.
// - Host strobes query addresses; device fetches and drives each statistic.
// - Result-valid register shows fetched data is valid.
// - End of acquisition sets done flag; interrupt only when enabled.
// - Hold flag late means measurements are discarded and cleared for next frame.
// - Host clears hold flag; device leaves readout and re-clears memory.
// - With commit flag set, shadow settings copy to active set on frame end rise.
// - Done flag sits in status bit 4.
module frame_stats_sequencer
  import fss_pkg::*;
#(
  parameter int DATA_WIDTH = 8
) (
  input  wire logic                     I_CLK,
  input  wire logic                     I_SRST,
  input  wire logic                     I_PIX_VALID,
  output logic                          O_PIX_READY,
  input  wire pix_t                     I_PIX,
  input  wire logic                     I_SOF,
  input  wire logic                     I_EOF,
  input  wire logic                     I_REG_WR,
  input  wire logic                     I_REG_RD,
  input  wire logic [`FSS_ADDR_W-1:0]   I_REG_ADDR,
  input  wire logic [31:0]              I_REG_WDATA,
  output logic      [31:0]              O_REG_RDATA,
  input  wire logic [DATA_WIDTH-1:0]    I_QUERY_ADDR,
  input  wire logic                     I_QUERY_STB,
  output logic      [31:0]              O_STAT_DATA,
  output logic                          O_STAT_VALID,
  output logic                          O_IRQ,
  output cfg_t                          O_ACTIVE_CFG
);
  localparam int BINS = 1 << DATA_WIDTH;

  initial begin
    if (DATA_WIDTH != 8 && DATA_WIDTH != 10 && DATA_WIDTH != `FSS_MAX_DATA_W) begin
      $error("frame_stats_sequencer: DATA_WIDTH must be 8, 10 or 12");
    end
  end

  // ==========================================================
  // Pixel buffer
  pix_t buf_pix;
  logic buf_valid, take;
  seq_state_t state_ff, nxt_state;

  fss_pix_buffer #(
    .WIDTH ($bits(pix_t)),
    .DEPTH (`FSS_BUF_DEPTH)
  ) u_buf (
    .i_clk       (I_CLK),
    .i_srst      (I_SRST),
    .i_in_valid  (I_PIX_VALID),
    .o_in_ready  (O_PIX_READY),
    .i_in_data   (I_PIX),
    .o_out_valid (buf_valid),
    .i_out_ready (state_ff != ST_INIT),
    .o_out_data  (buf_pix)
  );

  // Memory clearing owns the write port, so the stream stalls during it
  assign take = buf_valid && (state_ff != ST_INIT);

  // ==========================================================
  // Frame markers
  logic sof_d_ff, eof_d_ff, sof_rise, eof_rise;

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      sof_d_ff <= 1'b0;
      eof_d_ff <= 1'b0;
    end else begin
      sof_d_ff <= I_SOF;
      eof_d_ff <= I_EOF;
    end
  end

  assign sof_rise = I_SOF && !sof_d_ff;
  assign eof_rise = I_EOF && !eof_d_ff;

  // ==========================================================
  // Throughput counters
  logic [31:0] frame_cnt, line_cnt, pixel_cnt;

  fss_event_counter #(.WIDTH (32)) u_frame_cnt (
    .i_clk   (I_CLK),
    .i_srst  (I_SRST),
    .i_inc   (eof_rise),
    .o_count (frame_cnt)
  );

  fss_event_counter #(.WIDTH (32)) u_line_cnt (
    .i_clk   (I_CLK),
    .i_srst  (I_SRST),
    .i_inc   (take && buf_pix.eol),
    .o_count (line_cnt)
  );

  fss_event_counter #(.WIDTH (32)) u_pixel_cnt (
    .i_clk   (I_CLK),
    .i_srst  (I_SRST),
    .i_inc   (take),
    .o_count (pixel_cnt)
  );

  // ==========================================================
  // Registers written by the host
  logic [31:0] ctrl_ff, nxt_ctrl;
  logic        irq_en_ff, nxt_irq_en;
  logic        done_ff, nxt_done;
  cfg_t        shadow_ff, nxt_shadow, active_ff, nxt_active;
  logic        hold, commit, acq_end;

  assign hold    = ctrl_ff[`FSS_CTRL_HOLD_BIT];
  assign commit  = ctrl_ff[`FSS_CTRL_COMMIT_BIT];
  assign acq_end = (state_ff == ST_ACQ) && take && buf_pix.eaf;

  always_comb begin
    nxt_ctrl   = ctrl_ff;
    nxt_irq_en = irq_en_ff;
    nxt_shadow = shadow_ff;
    nxt_done   = done_ff;
    if (I_REG_WR) begin
      if (I_REG_ADDR == `FSS_OFS_CONTROL) begin
        nxt_ctrl = I_REG_WDATA;
      end else if (I_REG_ADDR == `FSS_OFS_STATUS) begin
        if (I_REG_WDATA[`FSS_STAT_DONE_BIT]) begin
          nxt_done = 1'b0;
        end
      end else if (I_REG_ADDR == `FSS_OFS_IRQ_EN) begin
        nxt_irq_en = I_REG_WDATA[`FSS_IRQ_DONE_BIT];
      end else if (I_REG_ADDR == `FSS_OFS_COL_LIMIT) begin
        nxt_shadow.col_limit = I_REG_WDATA[15:0];
      end else if (I_REG_ADDR == `FSS_OFS_ROW_LIMIT) begin
        nxt_shadow.row_limit = I_REG_WDATA[15:0];
      end else if (I_REG_ADDR == `FSS_OFS_COLOR_SEL) begin
        nxt_shadow.color_sel = I_REG_WDATA[15:0];
      end else if (I_REG_ADDR == `FSS_OFS_LUMA_SEL) begin
        nxt_shadow.luma_sel = I_REG_WDATA[15:0];
      end else if (I_REG_ADDR == `FSS_OFS_SCALE) begin
        nxt_shadow.scale = I_REG_WDATA[3:0];
      end
    end
    // A finishing frame beats a clear in the same cycle
    if (acq_end) begin
      nxt_done = 1'b1;
    end
    // Settings land together so a frame never sees a half-written set
    nxt_active = (eof_rise && commit) ? shadow_ff : active_ff;
  end

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      ctrl_ff   <= `FSS_RST_CONTROL;
      irq_en_ff <= 1'b0;
      done_ff   <= 1'b0;
      shadow_ff <= '{`FSS_RST_LIMIT, `FSS_RST_LIMIT, `FSS_RST_SEL, `FSS_RST_SEL, `FSS_RST_SCALE};
      active_ff <= '{`FSS_RST_LIMIT, `FSS_RST_LIMIT, `FSS_RST_SEL, `FSS_RST_SEL, `FSS_RST_SCALE};
    end else begin
      ctrl_ff   <= nxt_ctrl;
      irq_en_ff <= nxt_irq_en;
      done_ff   <= nxt_done;
      shadow_ff <= nxt_shadow;
      active_ff <= nxt_active;
    end
  end

  assign O_IRQ        = done_ff && irq_en_ff;
  assign O_ACTIVE_CFG = active_ff;

  // ==========================================================
  // Sequencer
  logic [DATA_WIDTH-1:0] clr_cnt_ff, nxt_clr_cnt;
  logic                  clr_last;

  assign clr_last = (clr_cnt_ff == DATA_WIDTH'(BINS - 1));

  always_comb begin
    nxt_state   = state_ff;
    nxt_clr_cnt = '0;
    case (state_ff)
      ST_INIT: begin
        nxt_clr_cnt = clr_cnt_ff + 1'b1;
        if (clr_last) begin
          nxt_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (sof_rise) begin
          nxt_state = ST_ACQ;
        end
      end
      ST_ACQ: begin
        if (acq_end) begin
          // Late hold means this frame is dropped and memory re-cleared
          nxt_state = hold ? ST_READ : ST_INIT;
        end
      end
      ST_READ: begin
        if (!hold) begin
          nxt_state = ST_INIT;
        end
      end
      default: begin
        nxt_state = ST_INIT;
      end
    endcase
  end

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      state_ff   <= ST_INIT;
      clr_cnt_ff <= '0;
    end else begin
      state_ff   <= nxt_state;
      clr_cnt_ff <= nxt_clr_cnt;
    end
  end

  // ==========================================================
  // Histogram memory and result fetch
  logic [31:0]           hist_mem [0:BINS-1];
  logic                  hist_we;
  logic [DATA_WIDTH-1:0] hist_addr;
  logic [31:0]           hist_wdata;
  logic [31:0]           stat_ff, nxt_stat;
  logic                  stat_vld_ff, nxt_stat_vld;

  always_comb begin
    hist_we    = 1'b0;
    hist_addr  = clr_cnt_ff;
    hist_wdata = '0;
    if (state_ff == ST_INIT) begin
      hist_we = 1'b1;
    end else if (state_ff == ST_ACQ && take) begin
      hist_we    = 1'b1;
      hist_addr  = buf_pix.data[DATA_WIDTH-1:0];
      hist_wdata = hist_mem[buf_pix.data[DATA_WIDTH-1:0]] + 32'h0000_0001;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (hist_we) begin
      hist_mem[hist_addr] <= hist_wdata;
    end
  end

  always_comb begin
    nxt_stat     = stat_ff;
    nxt_stat_vld = stat_vld_ff;
    if (state_ff != ST_READ) begin
      nxt_stat_vld = 1'b0;
    end else if (I_QUERY_STB) begin
      nxt_stat     = hist_mem[I_QUERY_ADDR];
      nxt_stat_vld = 1'b1;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      stat_ff     <= '0;
      stat_vld_ff <= 1'b0;
    end else begin
      stat_ff     <= nxt_stat;
      stat_vld_ff <= nxt_stat_vld;
    end
  end

  assign O_STAT_DATA  = stat_ff;
  assign O_STAT_VALID = stat_vld_ff;

  // ==========================================================
  // Register read
  logic [31:0] rdata_ff, nxt_rdata;

  always_comb begin
    nxt_rdata = rdata_ff;
    if (I_REG_RD) begin
      if (I_REG_ADDR == `FSS_OFS_CONTROL) begin
        nxt_rdata = ctrl_ff;
      end else if (I_REG_ADDR == `FSS_OFS_STATUS) begin
        nxt_rdata = 32'(done_ff) << `FSS_STAT_DONE_BIT;
      end else if (I_REG_ADDR == `FSS_OFS_IRQ_EN) begin
        nxt_rdata = 32'(irq_en_ff);
      end else if (I_REG_ADDR == `FSS_OFS_FRAME_CNT) begin
        nxt_rdata = frame_cnt;
      end else if (I_REG_ADDR == `FSS_OFS_LINE_CNT) begin
        nxt_rdata = line_cnt;
      end else if (I_REG_ADDR == `FSS_OFS_PIXEL_CNT) begin
        nxt_rdata = pixel_cnt;
      end else if (I_REG_ADDR == `FSS_OFS_COL_LIMIT) begin
        nxt_rdata = 32'(shadow_ff.col_limit);
      end else if (I_REG_ADDR == `FSS_OFS_ROW_LIMIT) begin
        nxt_rdata = 32'(shadow_ff.row_limit);
      end else if (I_REG_ADDR == `FSS_OFS_COLOR_SEL) begin
        nxt_rdata = 32'(shadow_ff.color_sel);
      end else if (I_REG_ADDR == `FSS_OFS_LUMA_SEL) begin
        nxt_rdata = 32'(shadow_ff.luma_sel);
      end else if (I_REG_ADDR == `FSS_OFS_SCALE) begin
        nxt_rdata = 32'(shadow_ff.scale);
      end else if (I_REG_ADDR == `FSS_OFS_RESULT_VLD) begin
        nxt_rdata = 32'(stat_vld_ff);
      end else begin
        nxt_rdata = '0;
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign O_REG_RDATA = rdata_ff;

  // ==========================================================
  // Checks
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SRST);

  property p_reset_init;
    $past(I_SRST) |-> state_ff == ST_INIT && clr_cnt_ff == '0;
  endproperty
  a_reset_init: assert property (p_reset_init) else $error("not in init after reset");

  property p_clear_done;
    state_ff == ST_INIT && clr_last |=> state_ff == ST_WAIT ##0 $past(hist_we, 2);
  endproperty
  a_clear_done: assert property (p_clear_done) else $error("clear did not end in wait");

  property p_wait_sof;
    state_ff == ST_WAIT && !sof_rise |=> state_ff == ST_WAIT;
  endproperty
  a_wait_sof: assert property (p_wait_sof) else $error("left wait without frame begin");

  property p_update_only_acq;
    hist_we && state_ff != ST_INIT |-> state_ff == ST_ACQ && take;
  endproperty
  a_update_only_acq: assert property (p_update_only_acq) else $error("update outside qualified pixel");

  property p_end_drop;
    acq_end && !hold |=> state_ff == ST_INIT ##1 clr_cnt_ff == DATA_WIDTH'(1);
  endproperty
  a_end_drop: assert property (p_end_drop) else $error("dropped frame did not re-clear");

  property p_end_hold;
    acq_end && hold |=> state_ff == ST_READ && done_ff;
  endproperty
  a_end_hold: assert property (p_end_hold) else $error("held frame did not enter readout");

  property p_fetch;
    state_ff == ST_READ && I_QUERY_STB |=> stat_vld_ff && stat_ff == $past(hist_mem[I_QUERY_ADDR]);
  endproperty
  a_fetch: assert property (p_fetch) else $error("query not answered");

  // The end of a frame must raise the done flag and expose it as an interrupt when enabled
  property p_irq;
    acq_end |=> done_ff && (O_IRQ == irq_en_ff);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt without enabled done");

  property p_leave_read;
    state_ff == ST_READ && !hold |=> state_ff == ST_INIT ##1 !stat_vld_ff;
  endproperty
  a_leave_read: assert property (p_leave_read) else $error("readout not left on release");

  property p_commit;
    eof_rise && commit |=> O_ACTIVE_CFG == $past(shadow_ff);
  endproperty
  a_commit: assert property (p_commit) else $error("settings not committed");

  property p_pixel_count;
    take |=> pixel_cnt == $past(pixel_cnt) + 32'h0000_0001;
  endproperty
  a_pixel_count: assert property (p_pixel_count) else $error("pixel count missed a step");
endmodule

// [tb/video_source_model.sv]
// Purpose : Upstream pixel source and frame marker model
// Assumes : Drives on the falling edge; a word is taken at the rising edge with ready high
// Notes   : Released data shows the inverse of the last word, so stale values never match
`timescale 1ns/1ns
module video_source_model
  import fss_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_ready,
  output logic      o_valid,
  output pix_t      o_pix,
  output logic      o_sof,
  output logic      o_eof,
  output logic      o_timeout
);
  initial begin
    o_valid = 1'b0;
    o_pix = '0;
    o_sof = 1'b0;
    o_eof = 1'b0;
    o_timeout = 1'b0;
  end

  // ==========================================================
  // Pixel words
  // Ready only moves at the rising edge, so looking at it on the falling edge is safe
  task automatic push(input logic [11:0] val, input logic eol, input logic eaf);
    int n;
    @(negedge i_clk);
    o_valid = 1'b1;
    o_pix = '{eaf, eol, val};
    n = 0;
    while (i_ready !== 1'b1 && n < 1000) begin
      @(negedge i_clk);
      n++;
    end
    if (n == 1000) begin
      o_timeout = 1'b1;
    end
    @(posedge i_clk);
  endtask

  task automatic idle(input int n);
    @(negedge i_clk);
    o_valid = 1'b0;
    o_pix = ~o_pix;
    repeat (n) @(negedge i_clk);
  endtask

  // ==========================================================
  // Frame markers: two-cycle level pulses, the rising edge is what counts
  task automatic mark(input bit end_of_frame);
    @(negedge i_clk);
    if (end_of_frame) o_eof = 1'b1;
    else o_sof = 1'b1;
    repeat (2) @(negedge i_clk);
    o_sof = 1'b0;
    o_eof = 1'b0;
  endtask
endmodule

// [tb/frame_stats_sequencer_tb_top.sv]
// Purpose : Self-checking bench for the frame statistics sequencer
// Assumes : DATA_WIDTH 8, so memory clearing lasts 256 cycles
// Notes   : Expected counts are tracked here from what the source model sent
`timescale 1ns/1ns
`include "fss_defs.svh"
module frame_stats_sequencer_tb_top
  import fss_pkg::*;
;
  logic        clk;
  logic        srst;
  logic        reg_wr;
  logic        reg_rd;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic [7:0]  query_addr;
  logic        query_stb;
  logic [31:0] stat_data;
  logic        stat_valid;
  logic        irq;
  cfg_t        active_cfg;
  logic        pix_valid;
  logic        pix_ready;
  pix_t        pix;
  logic        sof;
  logic        eof;
  logic        timeout;
  logic [31:0] rd;
  int          failures;
  int          checks;
  int          exp_pix;
  int          exp_line;
  int          exp_frame;
  cfg_t        rst_cfg;

  initial clk = 1'b0;
  always #2 clk = ~clk;

  frame_stats_sequencer #(.DATA_WIDTH(8)) i_frame_stats_sequencer (
    .I_CLK(clk), .I_SRST(srst), .I_PIX_VALID(pix_valid), .O_PIX_READY(pix_ready),
    .I_PIX(pix), .I_SOF(sof), .I_EOF(eof), .I_REG_WR(reg_wr), .I_REG_RD(reg_rd),
    .I_REG_ADDR(reg_addr), .I_REG_WDATA(reg_wdata), .O_REG_RDATA(reg_rdata),
    .I_QUERY_ADDR(query_addr), .I_QUERY_STB(query_stb), .O_STAT_DATA(stat_data),
    .O_STAT_VALID(stat_valid), .O_IRQ(irq), .O_ACTIVE_CFG(active_cfg));

  video_source_model i_video_source_model (
    .i_clk(clk), .i_ready(pix_ready), .o_valid(pix_valid), .o_pix(pix),
    .o_sof(sof), .o_eof(eof), .o_timeout(timeout));

  // ==========================================================
  // Shared tasks
  task automatic check(input logic [67:0] seen, input logic [67:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t %s seen %0h exp %0h", $time, what, seen, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask

  task automatic rdreg(input logic [11:0] a);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    rd = reg_rdata;
  endtask

  task automatic query(input logic [7:0] a, input logic [31:0] exp);
    @(negedge clk);
    query_stb = 1'b1;
    query_addr = a;
    @(negedge clk);
    query_stb = 1'b0;
    check(stat_data, exp, "bin count");
    check(stat_valid, 1'b1, "fetch valid");
  endtask

  task automatic send(input logic [7:0] v, input logic eol, input logic eaf);
    i_video_source_model.push({4'h0, v}, eol, eaf);
    exp_pix++;
    if (eol) exp_line++;
  endtask

  task automatic frame(input logic [7:0] v0, input logic [7:0] v1);
    i_video_source_model.mark(1'b0);
    send(v0, 1'b0, 1'b0);
    send(v1, 1'b1, 1'b0);
    i_video_source_model.idle(2);
    send(v0, 1'b0, 1'b0);
    send(v1, 1'b1, 1'b1);
    i_video_source_model.idle(6);
  endtask

  task automatic end_frame();
    i_video_source_model.mark(1'b1);
    exp_frame++;
  endtask

  task automatic counts();
    rdreg(`FSS_OFS_FRAME_CNT);
    check(rd, exp_frame, "frame count");
    rdreg(`FSS_OFS_LINE_CNT);
    check(rd, exp_line, "line count");
    rdreg(`FSS_OFS_PIXEL_CNT);
    check(rd, exp_pix, "pixel count");
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_init();
    check(pix_ready, 1'b1, "ready after reset");
    check(irq, 1'b0, "irq after reset");
    check(active_cfg, rst_cfg, "cfg after reset");
    fork
      begin
        repeat (3) send(8'h01, 1'b0, 1'b0);
        i_video_source_model.idle(1);
      end
      begin
        repeat (228) @(negedge clk);
        rdreg(`FSS_OFS_PIXEL_CNT);
        check(rd, 32'h0, "no drain while clearing");
        check(pix_ready, 1'b0, "buffer full while clearing");
      end
    join
    repeat (30) @(negedge clk);
    counts();
    rdreg(12'h100);
    check(rd, 32'h0, "unmapped read");
    wr(`FSS_OFS_FRAME_CNT, 32'hFFFF_FFFF);
    rdreg(`FSS_OFS_FRAME_CNT);
    check(rd, 32'h0, "read-only count");
  endtask

  task automatic t_discard();
    frame(8'h05, 8'h07);
    rdreg(`FSS_OFS_STATUS);
    check(rd[`FSS_STAT_DONE_BIT], 1'b1, "done flag");
    check(irq, 1'b0, "irq masked");
    wr(`FSS_OFS_IRQ_EN, 32'h1);
    check(irq, 1'b1, "irq enabled");
    wr(`FSS_OFS_STATUS, 32'h10);
    check(irq, 1'b0, "irq cleared");
    wr(`FSS_OFS_IRQ_EN, 32'h0);
    wr(`FSS_OFS_CONTROL, 32'h40);
    @(negedge clk);
    query_stb = 1'b1;
    @(negedge clk);
    query_stb = 1'b0;
    check(stat_valid, 1'b0, "late hold gives no readout");
    end_frame();
    counts();
  endtask

  task automatic t_readout();
    repeat (280) @(negedge clk);
    send(8'h05, 1'b0, 1'b0);
    i_video_source_model.idle(2);
    frame(8'h05, 8'h07);
    query(8'h05, 32'h2);
    query(8'h07, 32'h2);
    query(8'hF8, 32'h0);
    rdreg(`FSS_OFS_RESULT_VLD);
    check(rd, 32'h1, "result valid register");
    send(8'h05, 1'b1, 1'b1);
    i_video_source_model.idle(4);
    query(8'h05, 32'h2);
    wr(`FSS_OFS_CONTROL, 32'h0);
    repeat (2) @(negedge clk);
    check(stat_valid, 1'b0, "readout left");
    wr(`FSS_OFS_CONTROL, 32'h40);
    repeat (280) @(negedge clk);
    i_video_source_model.mark(1'b0);
    send(8'h09, 1'b1, 1'b1);
    i_video_source_model.idle(6);
    query(8'h05, 32'h0);
    query(8'h09, 32'h1);
    wr(`FSS_OFS_CONTROL, 32'h0);
  endtask

  task automatic t_commit();
    wr(`FSS_OFS_COL_LIMIT, 32'h1234);
    wr(`FSS_OFS_ROW_LIMIT, 32'h5678);
    wr(`FSS_OFS_COLOR_SEL, 32'h00F0);
    wr(`FSS_OFS_LUMA_SEL, 32'h0F00);
    wr(`FSS_OFS_SCALE, 32'h9);
    end_frame();
    check(active_cfg, rst_cfg, "no commit when disabled");
    wr(`FSS_OFS_CONTROL, 32'h2);
    check(active_cfg, rst_cfg, "no commit before frame end");
    end_frame();
    check(active_cfg, {16'h1234, 16'h5678, 16'h00F0, 16'h0F00, 4'h9}, "commit");
    counts();
  endtask

  // Mid-run reset must zero the counters and drop committed settings
  task automatic t_reset();
    @(negedge clk);
    srst = 1'b1;
    repeat (10) @(negedge clk);
    srst = 1'b0;
    exp_pix = 0;
    exp_line = 0;
    exp_frame = 0;
    check(active_cfg, rst_cfg, "cfg after mid-run reset");
    check(stat_valid, 1'b0, "no fetch after reset");
    check(irq, 1'b0, "irq after mid-run reset");
    counts();
  endtask

  // ==========================================================
  // Verdict and main sequence
  task automatic give_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge timeout) begin
    failures++;
    give_verdict();
  end

  initial begin
    rst_cfg = {`FSS_RST_LIMIT, `FSS_RST_LIMIT, `FSS_RST_SEL, `FSS_RST_SEL, `FSS_RST_SCALE};
    failures = 0;
    checks = 0;
    exp_pix = 0;
    exp_line = 0;
    exp_frame = 0;
    srst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 12'h000;
    reg_wdata = 32'h0;
    query_addr = 8'h00;
    query_stb = 1'b0;
    repeat (10) @(negedge clk);
    srst = 1'b0;
    t_init();
    t_discard();
    t_readout();
    t_commit();
    t_reset();
    give_verdict();
  end
endmodule
